// file: smdb_pkg.sv
// constants and types shared by the spi master buffer-engine block
package smdb_pkg;

  localparam int          ADDR_W       = 12;
  localparam int          CNT_W        = 10;
  localparam int          LIST_W       = 2;
  localparam int          IDX_W        = 11;

  localparam logic [11:0] OFS_TASK     = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h400;
  localparam logic [11:0] OFS_RX_PTR   = 12'h534;
  localparam logic [11:0] OFS_RX_LIMIT = 12'h538;
  localparam logic [11:0] OFS_RX_DONE  = 12'h53c;
  localparam logic [11:0] OFS_RX_LIST  = 12'h540;
  localparam logic [11:0] OFS_TX_PTR   = 12'h544;
  localparam logic [11:0] OFS_TX_LIMIT = 12'h548;
  localparam logic [11:0] OFS_TX_DONE  = 12'h54c;
  localparam logic [11:0] OFS_TX_LIST  = 12'h550;
  localparam logic [11:0] OFS_CFG      = 12'h554;
  localparam logic [11:0] OFS_FILL     = 12'h5c0;

  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [1:0]  LIST_ARRAY   = 2'h1;

  localparam int          CFG_ORDER    = 0;
  localparam int          CFG_CPHA     = 1;
  localparam int          CFG_CPOL     = 2;
  localparam int          CFG_W        = 3;
  localparam int          TASK_START   = 0;
  localparam int          STAT_BUSY    = 0;

  // link-clock cycles per serial clock half period
  localparam logic [2:0]  HALF_CYC     = 3'h4;
  localparam logic [4:0]  LAST_EDGE    = 5'h0f;

  typedef enum {
    C_IDLE, C_FETCH, C_SEND, C_WAIT, C_STORE, C_DONE
  } smdb_core_st_t;

  typedef enum {
    L_IDLE, L_SHIFT, L_TAIL
  } smdb_link_st_t;

endpackage

// file: smdb_xfer_if.sv
// byte handshake between the core-clock engine and the link shifter
`timescale 1ns/1ns
interface smdb_xfer_if;
  logic       req_tgl;
  logic [7:0] tx_byte;
  logic       low_bit_leading;
  logic       cpha;
  logic       cpol;
  logic       frame;
  logic       ack_tgl;
  logic [7:0] rx_byte;

  modport core (
    output req_tgl,
    output tx_byte,
    output low_bit_leading,
    output cpha,
    output cpol,
    output frame,
    input  ack_tgl,
    input  rx_byte
  );

  modport link (
    input  req_tgl,
    input  tx_byte,
    input  low_bit_leading,
    input  cpha,
    input  cpol,
    input  frame,
    output ack_tgl,
    output rx_byte
  );
endinterface

// file: smdb_shifter.sv
// serial shifter on the link clock: one full-duplex byte per request
`timescale 1ns/1ns
module smdb_shifter (
  input  wire logic   ser_clk,
  input  wire logic   ser_rst,
  smdb_xfer_if.link   xf,
  input  wire logic   miso,
  output logic        sck,
  output logic        mosi,
  output logic        cs_n
);

  smdb_pkg::smdb_link_st_t state_r;
  logic       req_m, req_s, req_p;
  logic       frm_m, frm_s;
  logic       pol_m, pol_s;
  logic       miso_m, miso_s;
  logic [2:0] half_r;
  logic [4:0] edge_r;
  logic       lvl_r;
  logic       cpha_r;
  logic       lsb_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_out_r;
  logic       ack_r;
  logic       cs_n_r;
  logic [7:0] tx_rev;
  logic [7:0] rx_rev;
  logic       tick;
  logic       smp_edge;

  ////////////////////////////////////////////////////////////////////////////
  // level crossings into the link domain
  always_ff @(posedge ser_clk) begin
    req_m  <= xf.req_tgl;
    req_s  <= req_m;
    frm_m  <= xf.frame;
    frm_s  <= frm_m;
    pol_m  <= xf.cpol;
    pol_s  <= pol_m;
    miso_m <= miso;
    miso_s <= miso_m;
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_rev
      assign tx_rev[b] = xf.tx_byte[7-b];
      assign rx_rev[b] = rx_sh_r[7-b];
    end
  endgenerate

  assign tick     = (half_r == smdb_pkg::HALF_CYC - 3'h1);
  // even edges lead, odd ones trail
  assign smp_edge = (edge_r[0] == cpha_r);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ser_clk) begin
    if (ser_rst) begin
      state_r  <= smdb_pkg::L_IDLE;
      req_p    <= 1'b0;
      half_r   <= 3'h0;
      edge_r   <= 5'h00;
      lvl_r    <= 1'b0;
      cpha_r   <= 1'b0;
      lsb_r    <= 1'b0;
      tx_sh_r  <= smdb_pkg::RST_BYTE;
      rx_sh_r  <= smdb_pkg::RST_BYTE;
      rx_out_r <= smdb_pkg::RST_BYTE;
      ack_r    <= 1'b0;
    end else begin
      case (state_r)
        smdb_pkg::L_IDLE: begin
          lvl_r  <= pol_s;
          half_r <= 3'h0;
          edge_r <= 5'h00;
          if (req_s != req_p) begin
            // byte and format are stable once the toggle is seen
            req_p   <= req_s;
            cpha_r  <= xf.cpha;
            lsb_r   <= xf.low_bit_leading;
            tx_sh_r <= xf.low_bit_leading ? tx_rev : xf.tx_byte;
            state_r <= smdb_pkg::L_SHIFT;
          end
        end
        smdb_pkg::L_SHIFT: begin
          half_r <= tick ? 3'h0 : half_r + 3'h1;
          if (tick) begin
            lvl_r  <= ~lvl_r;
            edge_r <= edge_r + 5'h01;
            if (smp_edge) begin
              rx_sh_r <= {rx_sh_r[6:0], miso_s};
            end else if (!(cpha_r && edge_r == 5'h00)) begin
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            if (edge_r == smdb_pkg::LAST_EDGE) begin
              state_r <= smdb_pkg::L_TAIL;
            end
          end
        end
        smdb_pkg::L_TAIL: begin
          half_r <= tick ? 3'h0 : half_r + 3'h1;
          if (tick) begin
            rx_out_r <= lsb_r ? rx_rev : rx_sh_r;
            ack_r    <= ~ack_r;
            state_r  <= smdb_pkg::L_IDLE;
          end
        end
        default: state_r <= smdb_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge ser_clk) begin
    if (ser_rst) begin
      cs_n_r <= 1'b1;
    end else begin
      cs_n_r <= ~frm_s;
    end
  end

  assign xf.ack_tgl = ack_r;
  assign xf.rx_byte = rx_out_r;
  assign sck        = lvl_r;
  assign mosi       = tx_sh_r[7];
  assign cs_n       = cs_n_r;

endmodule

// file: smdb_top.sv
// spi master with buffer engine: apb registers, fetch/store engine, link
`timescale 1ns/1ns
module smdb_top (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        SER_CLK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [31:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        MEM_READY,
  output logic             SCK,
  output logic             MOSI,
  input  wire logic        MISO,
  output logic             CS_N
);

  smdb_xfer_if xf ();

  smdb_pkg::smdb_core_st_t state_r;

  logic [31:0] rx_ptr_r;
  logic [31:0] tx_ptr_r;
  logic [9:0]  rx_limit_r;
  logic [9:0]  tx_limit_r;
  logic [9:0]  rx_done_r;
  logic [9:0]  tx_done_r;
  logic [1:0]  rx_list_r;
  logic [1:0]  tx_list_r;
  logic [2:0]  cfg_r;
  logic [7:0]  fill_r;
  logic [31:0] prdata_r;

  logic [10:0] idx_r;
  logic [10:0] idx_nxt;
  logic [10:0] total;
  logic [9:0]  rx_cnt_r;
  logic [9:0]  tx_cnt_r;
  logic [31:0] tx_addr_r;
  logic [31:0] rx_addr_r;
  logic [7:0]  tx_byte_r;
  logic [7:0]  rx_byte_r;
  logic        req_r;
  logic        frame_r;
  logic        ack_m;
  logic        ack_s;
  logic        ack_p;
  logic        srl_m;
  logic        ser_rst;

  logic        apb_wr;
  logic        apb_setup;
  logic        busy;
  logic        wr_ok;
  logic        start;
  logic        tx_from_mem;
  logic        rx_to_mem;
  logic        fetch_done;
  logic        store_done;
  logic        hit;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: read data latched in setup, no wait states
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE;
  assign busy      = (state_r != smdb_pkg::C_IDLE);
  // config stays frozen while a transaction runs; such writes drop silently
  assign wr_ok     = apb_wr & ~busy;
  assign start     = wr_ok & (PADDR == smdb_pkg::OFS_TASK)
                   & PWDATA[smdb_pkg::TASK_START];

  always_comb begin
    hit    = 1'b1;
    rd_mux = smdb_pkg::RST_WORD;
    case (PADDR)
      smdb_pkg::OFS_TASK:     rd_mux = smdb_pkg::RST_WORD;
      smdb_pkg::OFS_STATUS:   rd_mux[smdb_pkg::STAT_BUSY] = busy;
      smdb_pkg::OFS_RX_PTR:   rd_mux = rx_ptr_r;
      smdb_pkg::OFS_RX_LIMIT: rd_mux[9:0] = rx_limit_r;
      smdb_pkg::OFS_RX_DONE:  rd_mux[9:0] = rx_done_r;
      smdb_pkg::OFS_RX_LIST:  rd_mux[1:0] = rx_list_r;
      smdb_pkg::OFS_TX_PTR:   rd_mux = tx_ptr_r;
      smdb_pkg::OFS_TX_LIMIT: rd_mux[9:0] = tx_limit_r;
      smdb_pkg::OFS_TX_DONE:  rd_mux[9:0] = tx_done_r;
      smdb_pkg::OFS_TX_LIST:  rd_mux[1:0] = tx_list_r;
      smdb_pkg::OFS_CFG:      rd_mux[2:0] = cfg_r;
      smdb_pkg::OFS_FILL:     rd_mux[7:0] = fill_r;
      default:                hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prdata_r <= smdb_pkg::RST_WORD;
    end else if (apb_setup && !PWRITE) begin
      prdata_r <= rd_mux;
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rx_limit_r <= 10'h000;
      tx_limit_r <= 10'h000;
      rx_list_r  <= 2'h0;
      tx_list_r  <= 2'h0;
      cfg_r      <= 3'h0;
      fill_r     <= smdb_pkg::RST_BYTE;
    end else if (wr_ok) begin
      case (PADDR)
        smdb_pkg::OFS_RX_LIMIT: rx_limit_r <= PWDATA[9:0];
        smdb_pkg::OFS_TX_LIMIT: tx_limit_r <= PWDATA[9:0];
        smdb_pkg::OFS_RX_LIST:  rx_list_r  <= PWDATA[1:0];
        smdb_pkg::OFS_TX_LIST:  tx_list_r  <= PWDATA[1:0];
        smdb_pkg::OFS_CFG:      cfg_r      <= PWDATA[2:0];
        smdb_pkg::OFS_FILL:     fill_r     <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // pointers: written by software, stepped by hardware in list mode;
  // list values other than one leave the pointer where it is
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rx_ptr_r <= smdb_pkg::RST_WORD;
    end else if (wr_ok && PADDR == smdb_pkg::OFS_RX_PTR) begin
      rx_ptr_r <= PWDATA;
    end else if (state_r == smdb_pkg::C_DONE
                 && rx_list_r == smdb_pkg::LIST_ARRAY) begin
      rx_ptr_r <= rx_ptr_r + {22'h0, rx_limit_r};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_ptr_r <= smdb_pkg::RST_WORD;
    end else if (wr_ok && PADDR == smdb_pkg::OFS_TX_PTR) begin
      tx_ptr_r <= PWDATA;
    end else if (state_r == smdb_pkg::C_DONE
                 && tx_list_r == smdb_pkg::LIST_ARRAY) begin
      tx_ptr_r <= tx_ptr_r + {22'h0, tx_limit_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine
  // a run lasts as long as the longer of the two buffers
  assign total       = (rx_limit_r > tx_limit_r) ? {1'b0, rx_limit_r}
                                                 : {1'b0, tx_limit_r};
  assign tx_from_mem = (idx_r < {1'b0, tx_limit_r});
  assign rx_to_mem   = (idx_r < {1'b0, rx_limit_r});
  assign fetch_done  = ~tx_from_mem | MEM_READY;
  assign store_done  = ~rx_to_mem | MEM_READY;
  assign idx_nxt     = idx_r + 11'h001;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_r <= smdb_pkg::C_IDLE;
    end else begin
      case (state_r)
        smdb_pkg::C_IDLE: begin
          if (start) begin
            state_r <= (total == 11'h000) ? smdb_pkg::C_DONE
                                          : smdb_pkg::C_FETCH;
          end
        end
        smdb_pkg::C_FETCH: begin
          if (fetch_done) begin
            state_r <= smdb_pkg::C_SEND;
          end
        end
        smdb_pkg::C_SEND: state_r <= smdb_pkg::C_WAIT;
        smdb_pkg::C_WAIT: begin
          if (ack_s != ack_p) begin
            state_r <= smdb_pkg::C_STORE;
          end
        end
        smdb_pkg::C_STORE: begin
          if (store_done) begin
            state_r <= (idx_nxt == total) ? smdb_pkg::C_DONE
                                          : smdb_pkg::C_FETCH;
          end
        end
        smdb_pkg::C_DONE: state_r <= smdb_pkg::C_IDLE;
        default:          state_r <= smdb_pkg::C_IDLE;
      endcase
    end
  end

  // byte index and running buffer addresses
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      idx_r     <= 11'h000;
      tx_addr_r <= smdb_pkg::RST_WORD;
      rx_addr_r <= smdb_pkg::RST_WORD;
    end else if (start) begin
      idx_r     <= 11'h000;
      tx_addr_r <= tx_ptr_r;
      rx_addr_r <= rx_ptr_r;
    end else if (state_r == smdb_pkg::C_STORE && store_done) begin
      idx_r     <= idx_nxt;
      tx_addr_r <= tx_addr_r + 32'h0000_0001;
      rx_addr_r <= rx_addr_r + 32'h0000_0001;
    end
  end

  // outgoing byte: from the buffer while it lasts, then the fill character
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_byte_r <= smdb_pkg::RST_BYTE;
    end else if (state_r == smdb_pkg::C_FETCH && fetch_done) begin
      tx_byte_r <= tx_from_mem ? MEM_RDATA : fill_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rx_byte_r <= smdb_pkg::RST_BYTE;
      ack_p     <= 1'b0;
    end else if (state_r == smdb_pkg::C_WAIT && ack_s != ack_p) begin
      // link holds its byte until the next request, so it is settled here
      rx_byte_r <= xf.rx_byte;
      ack_p     <= ack_s;
    end
  end

  // live counts of bytes really moved through the buffers
  always_ff @(posedge CORE_CLK) begin
    if (SRST || start) begin
      tx_cnt_r <= 10'h000;
    end else if (state_r == smdb_pkg::C_FETCH && tx_from_mem
                 && MEM_READY) begin
      tx_cnt_r <= tx_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || start) begin
      rx_cnt_r <= 10'h000;
    end else if (state_r == smdb_pkg::C_STORE && rx_to_mem
                 && MEM_READY) begin
      rx_cnt_r <= rx_cnt_r + 10'h001;
    end
  end

  // amounts change only at the end, so a read mid-run shows the last one
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rx_done_r <= 10'h000;
    end else if (state_r == smdb_pkg::C_DONE) begin
      rx_done_r <= rx_cnt_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_done_r <= 10'h000;
    end else if (state_r == smdb_pkg::C_DONE) begin
      tx_done_r <= tx_cnt_r;
    end
  end

  // one toggle per byte; a level survives the crossing, a pulse may not
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      req_r <= 1'b0;
    end else if (state_r == smdb_pkg::C_SEND) begin
      req_r <= ~req_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      frame_r <= 1'b0;
    end else if (start) begin
      frame_r <= 1'b1;
    end else if (state_r == smdb_pkg::C_DONE) begin
      frame_r <= 1'b0;
    end
  end

  assign MEM_REQ   = (state_r == smdb_pkg::C_FETCH && tx_from_mem)
                   | (state_r == smdb_pkg::C_STORE && rx_to_mem);
  assign MEM_WE    = (state_r == smdb_pkg::C_STORE);
  assign MEM_ADDR  = MEM_WE ? rx_addr_r : tx_addr_r;
  assign MEM_WDATA = rx_byte_r;

  ////////////////////////////////////////////////////////////////////////////
  // crossings and link side
  always_ff @(posedge CORE_CLK) begin
    ack_m <= xf.ack_tgl;
    ack_s <= ack_m;
  end

  // the link domain gets its own copy of the reset
  always_ff @(posedge SER_CLK) begin
    srl_m   <= SRST;
    ser_rst <= srl_m;
  end

  assign xf.req_tgl         = req_r;
  assign xf.tx_byte         = tx_byte_r;
  assign xf.low_bit_leading = cfg_r[smdb_pkg::CFG_ORDER];
  assign xf.cpha            = cfg_r[smdb_pkg::CFG_CPHA];
  assign xf.cpol            = cfg_r[smdb_pkg::CFG_CPOL];
  assign xf.frame           = frame_r;

  smdb_shifter u_shifter (
    .ser_clk (SER_CLK),
    .ser_rst (ser_rst),
    .xf      (xf),
    .miso    (MISO),
    .sck     (SCK),
    .mosi    (MOSI),
    .cs_n    (CS_N)
  );

endmodule

// file: smdb_asserts.sv
// port-level assertions for the spi master buffer engine
`timescale 1ns/1ns
module smdb_asserts (
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        SER_CLK,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_READY,
  input wire logic        SCK,
  input wire logic        CS_N
);
  logic        wr_a;
  logic        go;
  logic        cpol_r;
  logic        pol_s;
  logic [3:0]  calm_r;
  logic [9:0]  tlim_r;
  logic [9:0]  rlim_r;
  logic [9:0]  fcnt_r;
  logic [9:0]  scnt_r;
  logic [31:0] fa_r;

  assign wr_a = PSEL && PENABLE && PWRITE;
  assign go   = wr_a && PADDR == smdb_pkg::OFS_TASK
              && PWDATA[smdb_pkg::TASK_START];
  ////////////////////////////////////////////////////////////////
  // shadows assume software leaves settings alone while busy
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tlim_r <= 10'h000;
      rlim_r <= 10'h000;
      cpol_r <= 1'b0;
    end else if (wr_a) begin
      if (PADDR == smdb_pkg::OFS_TX_LIMIT) tlim_r <= PWDATA[9:0];
      if (PADDR == smdb_pkg::OFS_RX_LIMIT) rlim_r <= PWDATA[9:0];
      if (PADDR == smdb_pkg::OFS_CFG) cpol_r <= PWDATA[2];
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (SRST || go) begin
      fcnt_r <= 10'h000;
      scnt_r <= 10'h000;
    end else if (MEM_REQ && MEM_READY && MEM_WE) begin
      scnt_r <= scnt_r + 10'h001;
    end else if (MEM_REQ && MEM_READY) begin
      fcnt_r <= fcnt_r + 10'h001;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (MEM_REQ && MEM_READY && !MEM_WE) fa_r <= MEM_ADDR;
  end
  // polarity needs time to cross into the link domain
  always_ff @(posedge SER_CLK) begin
    pol_s <= cpol_r;
    if (SRST || pol_s != cpol_r) calm_r <= 4'h0;
    else if (calm_r != 4'hf) calm_r <= calm_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_rd(logic [11:0] ofs);
    PSEL && !PENABLE && !PWRITE && PADDR == ofs;
  endsequence
  sequence s_stall;
    MEM_REQ && !MEM_READY;
  endsequence

  property p_tx_done;
    @(posedge CORE_CLK) disable iff (SRST)
    s_rd(smdb_pkg::OFS_TX_DONE) |=> PRDATA == {22'h0, fcnt_r};
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("tx count differs");
  property p_rx_done;
    @(posedge CORE_CLK) disable iff (SRST)
    s_rd(smdb_pkg::OFS_RX_DONE) |=> PRDATA == {22'h0, scnt_r};
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("rx count differs");
  property p_tlim;
    @(posedge CORE_CLK) disable iff (SRST)
    s_rd(smdb_pkg::OFS_TX_LIMIT) |=> PRDATA == {22'h0, tlim_r};
  endproperty
  a_tlim: assert property (p_tlim)
    else $error("tx limit readback");
  property p_fetch_bnd;
    @(posedge CORE_CLK) disable iff (SRST)
    MEM_REQ && !MEM_WE |-> fcnt_r < tlim_r;
  endproperty
  a_fetch_bnd: assert property (p_fetch_bnd)
    else $error("fetch past limit");
  property p_store_bnd;
    @(posedge CORE_CLK) disable iff (SRST)
    MEM_REQ && MEM_WE |-> scnt_r < rlim_r;
  endproperty
  a_store_bnd: assert property (p_store_bnd)
    else $error("store past limit");
  property p_mem_hold;
    @(posedge CORE_CLK) disable iff (SRST)
    s_stall |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped");
  property p_addr_seq;
    @(posedge CORE_CLK) disable iff (SRST)
    MEM_REQ && !MEM_WE && fcnt_r != 10'h000 |-> MEM_ADDR == fa_r + 32'h1;
  endproperty
  a_addr_seq: assert property (p_addr_seq)
    else $error("fetch address skipped");
  property p_sck_idle;
    @(posedge SER_CLK) disable iff (SRST)
    CS_N && calm_r == 4'hf |-> SCK == pol_s;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("idle clock level");
endmodule

bind smdb_top smdb_asserts u_asserts (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .SER_CLK(SER_CLK), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
  .MEM_ADDR(MEM_ADDR), .MEM_READY(MEM_READY), .SCK(SCK), .CS_N(CS_N)
);

// file: smdb_spi_slave.sv
// behavioural spi slave: repeats one answer byte, logs bytes heard
`timescale 1ns/1ns
module smdb_spi_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic [2:0] cfg,
  input  wire logic [7:0] tx_byte,
  output logic            miso
);
  logic [7:0] sh;
  logic [7:0] q[$];
  int         nb = 0;
  logic       m_r = 1'b0;
  logic       cs_q = 1'b1;

  function automatic logic pick(input int i);
    return cfg[0] ? tx_byte[i] : tx_byte[7-i];
  endfunction

  assign miso = m_r;
  // no pull on the line: released means inverse, never a stale bit
  always @(sck or cs_n) begin
    if (cs_n !== cs_q) begin
      cs_q = cs_n;
      nb = 0;
      m_r = (cs_n === 1'b0) ? pick(0) : ~m_r;
    end else if (cs_n === 1'b0) begin
      if ((sck != cfg[2]) != cfg[1]) begin
        sh = cfg[0] ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        nb = nb + 1;
        if (nb == 8) begin
          q.push_back(sh);
          nb = 0;
        end
      end else begin
        m_r = pick(nb);
      end
    end
  end
endmodule

// file: smdb_tb_top.sv
// self-checking bench: apb master, buffer memory and spi slave
`timescale 1ns/1ns
module smdb_tb_top;
  localparam logic [11:0] RG [8] = '{smdb_pkg::OFS_RX_DONE,
    smdb_pkg::OFS_RX_LIST, smdb_pkg::OFS_TX_PTR, smdb_pkg::OFS_TX_LIMIT,
    smdb_pkg::OFS_TX_DONE, smdb_pkg::OFS_TX_LIST, smdb_pkg::OFS_CFG,
    smdb_pkg::OFS_FILL};
  localparam logic [31:0] MSK [8] = '{32'h0, 32'h3, 32'hffff_ffff,
    32'h3ff, 32'h0, 32'h3, 32'h7, 32'hff};
  logic        clk = 1'b0;
  logic        ser_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        mem_ready = 1'b0;
  logic [2:0]  s_cfg = 3'h0;
  logic [7:0]  s_byte = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mem_req;
  logic        mem_we;
  logic [31:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        cs_n;
  logic        err;
  logic [7:0]  mem [256];
  logic [31:0] rq[$];
  logic [31:0] wa[$];
  logic [7:0]  wd[$];
  int          n_errors = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;
  initial begin
    #3;
    forever begin
      #7 ser_clk = 1'b1;
      #8 ser_clk = 1'b0;
    end
  end
  smdb_top dut (.CORE_CLK(clk), .SRST(srst), .SER_CLK(ser_clk),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .MEM_READY(mem_ready), .SCK(sck), .MOSI(mosi), .MISO(miso),
    .CS_N(cs_n));
  smdb_spi_slave slv (.sck(sck), .mosi(mosi), .cs_n(cs_n), .cfg(s_cfg),
    .tx_byte(s_byte), .miso(miso));
  ////////////////////////////////////////////////////////////////
  // buffer memory stalls at random; data is junk while not ready
  assign mem_rdata = mem_ready ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
  always @(posedge clk) begin
    mem_ready <= ($urandom % 3) != 0;
    if (mem_req && mem_ready && mem_we) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end else if (mem_req && mem_ready) begin
      rq.push_back(mem_addr);
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  function automatic logic [7:0] want(input int i, input int t,
    input logic [31:0] tp, input logic [7:0] fill);
    return (i < t) ? mem[8'(tp + 32'(i))] : fill;
  endfunction
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // pointers are written by the caller so list stepping can be seen
  task automatic run(input logic [31:0] tp, input logic [31:0] rp,
                     input int t, input int r, input logic [2:0] cfg);
    logic [31:0] v;
    logic [7:0]  fill;
    int          k;
    fill = 8'($urandom);
    wr(smdb_pkg::OFS_TX_LIMIT, 32'(t));
    wr(smdb_pkg::OFS_RX_LIMIT, 32'(r));
    wr(smdb_pkg::OFS_CFG, {29'h0, cfg});
    wr(smdb_pkg::OFS_FILL, {24'h0, fill});
    s_cfg <= cfg;
    s_byte <= 8'($urandom);
    rq.delete();
    wa.delete();
    wd.delete();
    slv.q.delete();
    wr(smdb_pkg::OFS_TASK, 32'h1);
    v = 32'h1;
    for (k = 0; k < 4000 && v[0] !== 1'b0; k++)
      apb(1'b0, smdb_pkg::OFS_STATUS, 32'h0, v);
    for (k = 0; k < 60 && cs_n !== 1'b1; k++) @(posedge clk);
    chk({31'h0, v[0]}, 32'h0);
    chk({31'h0, sck}, {31'h0, cfg[2]});
    chk(32'(slv.q.size()), 32'((t > r) ? t : r));
    foreach (slv.q[i]) chk(slv.q[i], want(i, t, tp, fill));
    chk(32'(rq.size()), 32'(t));
    foreach (rq[i]) chk(rq[i], tp + 32'(i));
    chk(32'(wa.size()), 32'(r));
    foreach (wa[i]) chk(wa[i], rp + 32'(i));
    foreach (wd[i]) chk({24'h0, wd[i]}, {24'h0, s_byte});
    apb(1'b0, smdb_pkg::OFS_TX_DONE, 32'h0, v);
    chk(v, 32'(t));
    apb(1'b0, smdb_pkg::OFS_RX_DONE, 32'h0, v);
    chk(v, 32'(r));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    logic [31:0] v;
    logic [31:0] tp;
    void'($urandom(32'h94c0));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (RG[i]) begin
      apb(1'b0, RG[i], 32'h0, v);
      chk(v, smdb_pkg::RST_WORD);
      chk({30'h0, pready, err}, 32'h2);
      wr(RG[i], 32'hffff_ffff);
      apb(1'b0, RG[i], 32'h0, v);
      chk(v, MSK[i]);
    end
    apb(1'b0, 12'h0f0, 32'h0, v);
    chk({31'h0, err}, 32'h1);
    wr(smdb_pkg::OFS_TX_LIST, 32'h0);
    wr(smdb_pkg::OFS_RX_LIST, 32'h0);
    wr(smdb_pkg::OFS_TX_PTR, 32'h10);
    wr(smdb_pkg::OFS_RX_PTR, 32'h80);
    run(32'h10, 32'h80, 0, 0, 3'h0);
    run(32'h10, 32'h80, 1, 3, 3'h6);
    run(32'h10, 32'h80, 4, 0, 3'h1);
    for (int m = 0; m < 16; m++) begin
      tp = 32'($urandom % 200);
      wr(smdb_pkg::OFS_TX_PTR, tp);
      wr(smdb_pkg::OFS_RX_PTR, tp + 32'h2000);
      run(tp, tp + 32'h2000, $urandom % 4, $urandom % 4, 3'(m));
    end
    wr(smdb_pkg::OFS_TX_LIST, 32'(smdb_pkg::LIST_ARRAY));
    wr(smdb_pkg::OFS_RX_LIST, 32'(smdb_pkg::LIST_ARRAY));
    wr(smdb_pkg::OFS_TX_PTR, 32'h40);
    wr(smdb_pkg::OFS_RX_PTR, 32'h90);
    run(32'h40, 32'h90, 2, 3, 3'h3);
    run(32'h42, 32'h93, 3, 1, 3'h4);
    report_and_stop();
  end
endmodule
